// ===== design/dcc_exec.sv
// decode and execute for debug break, calls and compares
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module dcc_exec import dcc_pkg::*; #(
  parameter logic [DataW-1:0] BreakHandlerAddr = 32'h0000_0020
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction issue
  input wire logic instrValid,
  input wire logic [DataW-1:0] instrWord,
  // register file read ports
  output logic [RegIdxW-1:0] rdIdxA,
  output logic [RegIdxW-1:0] rdIdxB,
  input wire logic [DataW-1:0] rdDataA,
  input wire logic [DataW-1:0] rdDataB,
  // register file write port
  output logic wrEn,
  output logic [RegIdxW-1:0] wrIdx,
  output logic [DataW-1:0] wrData,
  // program counter and status
  output logic [DataW-1:0] pcOut,
  output logic [StatusW-1:0] statusOut,
  output logic [StatusW-1:0] savedStatusOut,
  // not in this slice
  output logic unimplPulse
);
  // ***************************************************
  // reset synchroniser
  // ***************************************************
  logic rstMeta_q, rstSync_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ***************************************************
  // field extraction
  // ***************************************************
  logic [OpW-1:0] opc;
  logic [XopW-1:0] xop;
  logic [RegIdxW-1:0] fA, fB, fC;
  logic [ImmW-1:0] sixteen_bit_imm;
  logic [JmpW-1:0] jmpTarget;
  assign opc = instrWord[OpLsb +: OpW];
  assign xop = instrWord[XopLsb +: XopW];
  assign fA = instrWord[ALsb +: RegIdxW];
  assign fB = instrWord[BLsb +: RegIdxW];
  assign fC = instrWord[CLsb +: RegIdxW];
  assign sixteen_bit_imm = instrWord[ImmLsb +: ImmW];
  assign jmpTarget = instrWord[ImmLsb +: JmpW];
  // the tag field at TagLsb is never decoded, so break and break 0 match

  // ***************************************************
  // decode
  // ***************************************************
  typedef enum logic [3:0] {
    DCC_NONE = 4'h0,
    DCC_BRK = 4'h1,
    DCC_BRET = 4'h2,
    DCC_CALL = 4'h3,
    DCC_CALLR = 4'h4,
    DCC_CEQ = 4'h5,
    DCC_CGE = 4'h6,
    DCC_CGEU = 4'h7,
    DCC_CEQI = 4'h8,
    DCC_CGEI = 4'h9,
    DCC_CGEUI = 4'hA
  } dcc_op_t;
  dcc_op_t op;
  always_comb begin
    op = DCC_NONE;
    unique case (opc)
      OpRType: begin
        if (xop == XopBreak) begin
          op = DCC_BRK;
        end else if (xop == XopBret) begin
          op = DCC_BRET;
        end else if (xop == XopCallr) begin
          op = DCC_CALLR;
        end else if (xop == XopCmpEq) begin
          op = DCC_CEQ;
        end else if (xop == XopCmpGe) begin
          op = DCC_CGE;
        end else if (xop == XopCmpGeU) begin
          op = DCC_CGEU;
        end
      end
      OpCall: op = DCC_CALL;
      OpCmpEqI: op = DCC_CEQI;
      OpCmpGeI: op = DCC_CGEI;
      OpCmpGeUI: op = DCC_CGEUI;
      default: op = DCC_NONE;
    endcase
  end

  // ***************************************************
  // operands and compare
  // ***************************************************
  logic isImm, isCmp;
  logic [DataW-1:0] immExt, cmpB, cmpRes, linkAddr;
  assign isImm = (op == DCC_CEQI) || (op == DCC_CGEI) || (op == DCC_CGEUI);
  assign isCmp = isImm || (op == DCC_CEQ) || (op == DCC_CGE) || (op == DCC_CGEU);
  always_comb begin
    if (op == DCC_CGEUI) begin
      immExt = {{(DataW-ImmW){1'b0}}, sixteen_bit_imm};
    end else begin
      immExt = {{(DataW-ImmW){sixteen_bit_imm[ImmW-1]}}, sixteen_bit_imm};
    end
  end
  assign cmpB = isImm ? immExt : rdDataB;
  assign rdIdxA = fA;
  assign rdIdxB = fB;
  assign linkAddr = pcOut + InstrBytes;

  dcc_compare #(.Width(DataW)) uCmp (
    .opA(rdDataA),
    .opB(cmpB),
    .isEqual((op == DCC_CEQ) || (op == DCC_CEQI)),
    .isSigned((op == DCC_CGE) || (op == DCC_CGEI)),
    .result(cmpRes)
  );

  // ***************************************************
  // register file write
  // ***************************************************
  logic wrEn_d;
  logic [RegIdxW-1:0] wrIdx_d;
  logic [DataW-1:0] wrData_d;
  always_comb begin
    wrEn_d = 1'b0;
    wrIdx_d = RegZero;
    wrData_d = cmpRes;
    if (instrValid) begin
      if (isCmp) begin
        wrEn_d = 1'b1;
        wrIdx_d = isImm ? fB : fC;
      end else if (op == DCC_CALL || op == DCC_CALLR) begin
        wrEn_d = 1'b1;
        wrIdx_d = RegRa;
        wrData_d = linkAddr;
      end else if (op == DCC_BRK) begin
        wrEn_d = 1'b1;
        wrIdx_d = RegBa;
        wrData_d = linkAddr;
      end
    end
    if (wrIdx_d == RegZero) begin
      wrEn_d = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      wrEn <= 1'b0;
      wrIdx <= RegZero;
      wrData <= PcRst;
    end else begin
      wrEn <= wrEn_d;
      wrIdx <= wrIdx_d;
      wrData <= wrData_d;
    end
  end

  // ***************************************************
  // program counter
  // ***************************************************
  logic [DataW-1:0] breakRet_q;
  logic [DataW-1:0] pc_d;
  always_comb begin
    pc_d = pcOut;
    if (instrValid) begin
      pc_d = linkAddr;
      unique case (op)
        DCC_BRK: pc_d = BreakHandlerAddr;
        DCC_BRET: pc_d = breakRet_q;
        // word-aligned target: the two low address bits are always zero
        DCC_CALL: pc_d = {pcOut[RegionLsb +: RegionW], jmpTarget, {WordShift{1'b0}}};
        DCC_CALLR: pc_d = rdDataA;
        default: pc_d = linkAddr;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pcOut <= PcRst;
    end else begin
      pcOut <= pc_d;
    end
  end

  // break return address kept locally beside the register file copy
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      breakRet_q <= PcRst;
    end else if (instrValid && op == DCC_BRK) begin
      breakRet_q <= linkAddr;
    end
  end

  // ***************************************************
  // status and saved status
  // ***************************************************
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      statusOut <= StatusRst;
      savedStatusOut <= StatusRst;
    end else if (instrValid && op == DCC_BRK) begin
      savedStatusOut <= statusOut;
      statusOut[PieBit] <= 1'b0;
      statusOut[UserBit] <= 1'b0;
    end else if (instrValid && op == DCC_BRET) begin
      statusOut <= savedStatusOut;
    end
  end

  // ***************************************************
  // unrecognised opcodes
  // ***************************************************
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      unimplPulse <= 1'b0;
    end else begin
      unimplPulse <= instrValid && (op == DCC_NONE);
    end
  end
endmodule
`default_nettype wire

// ===== design/dcc_pkg.sv
// constants and encodings for the debug, call and compare instruction slice
// Operation
// - break saves status, masks, links, jumps handler
// - five-bit tag field ignored by execution
// - break is register format, extended 0x34
// - break handler address fixed by parameter
// - break return restores status, jumps saved
// - direct call links, jumps region plus target
// - indirect call links, jumps to src_reg_a
// - equal compare writes one or zero
// - register compares use A, B, C fields
// - equal immediate compare, sign-extended, writes B
// - signed greater-or-equal register compare
// - unsigned greater-or-equal register compare
// - signed greater-or-equal immediate compare, opcode 0x08
// - unsigned immediate compare, zero-extended, opcode 0x28
package dcc_pkg;
  localparam int unsigned DataW = 32;
  localparam int unsigned RegIdxW = 5;
  localparam int unsigned OpW = 6;
  localparam int unsigned XopW = 6;
  // field positions
  localparam int unsigned OpLsb = 0;
  localparam int unsigned ImmLsb = 6;
  localparam int unsigned ImmW = 16;
  localparam int unsigned TagLsb = 6;
  localparam int unsigned TagW = 5;
  localparam int unsigned XopLsb = 11;
  localparam int unsigned CLsb = 17;
  localparam int unsigned BLsb = 22;
  localparam int unsigned ALsb = 27;
  localparam int unsigned JmpW = 26;
  localparam int unsigned RegionLsb = 28;
  localparam int unsigned RegionW = 4;
  localparam int unsigned WordShift = 2;
  // primary opcodes
  localparam logic [OpW-1:0] OpRType = 6'h3A;
  localparam logic [OpW-1:0] OpCall = 6'h00;
  localparam logic [OpW-1:0] OpCmpEqI = 6'h20;
  localparam logic [OpW-1:0] OpCmpGeI = 6'h08;
  localparam logic [OpW-1:0] OpCmpGeUI = 6'h28;
  // extended opcodes
  localparam logic [XopW-1:0] XopBreak = 6'h34;
  localparam logic [XopW-1:0] XopBret = 6'h09;
  localparam logic [XopW-1:0] XopCallr = 6'h1D;
  localparam logic [XopW-1:0] XopCmpEq = 6'h20;
  localparam logic [XopW-1:0] XopCmpGe = 6'h08;
  localparam logic [XopW-1:0] XopCmpGeU = 6'h28;
  // status register layout
  localparam int unsigned StatusW = 32;
  localparam int unsigned PieBit = 0;
  localparam int unsigned UserBit = 1;
  localparam logic [StatusW-1:0] StatusRst = 32'h0000_0000;
  localparam logic [DataW-1:0] PcRst = 32'h0000_0000;
  localparam logic [DataW-1:0] InstrBytes = 32'h0000_0004;
  localparam logic [RegIdxW-1:0] RegZero = 5'h00;
  localparam logic [RegIdxW-1:0] RegRa = 5'h1F;
  localparam logic [RegIdxW-1:0] RegBa = 5'h1E;
endpackage

// ===== design/dcc_compare.sv
// compare unit producing a zero-extended one-bit result
`timescale 1ns/10ps
`default_nettype none
module dcc_compare import dcc_pkg::*; #(
  parameter int unsigned Width = DataW
) (
  // operands
  input wire logic [Width-1:0] opA,
  input wire logic [Width-1:0] opB,
  // selection
  input wire logic isEqual,
  input wire logic isSigned,
  // result
  output logic [Width-1:0] result
);
  logic hit;
  always_comb begin
    if (isEqual) begin
      hit = (opA == opB);
    end else if (isSigned) begin
      hit = ($signed(opA) >= $signed(opB));
    end else begin
      hit = (opA >= opB);
    end
    result = {{(Width-1){1'b0}}, hit};
  end
endmodule
`default_nettype wire

// ===== dv/dcc_exec_properties.sv
// checker for the debug, call and compare slice
`timescale 1ns/10ps
`default_nettype none
module dcc_exec_chk import dcc_pkg::*; #(
  parameter logic [DataW-1:0] BreakHandlerAddr = 32'h0000_0020
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue
  input wire logic instrValid,
  input wire logic [DataW-1:0] instrWord,
  input wire logic [DataW-1:0] rdDataA,
  input wire logic [DataW-1:0] rdDataB,
  // results
  input wire logic wrEn,
  input wire logic [RegIdxW-1:0] wrIdx,
  input wire logic [DataW-1:0] wrData,
  input wire logic [DataW-1:0] pcOut,
  input wire logic [StatusW-1:0] statusOut,
  input wire logic [StatusW-1:0] savedStatusOut,
  input wire logic unimplPulse
);
  // ****
  // issue capture
  // ****
  logic prevVld_q;
  logic [DataW-1:0] prevWord_q;
  logic [DataW-1:0] prevPc_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevVld_q <= 1'b0;
      prevWord_q <= 32'h0000_0000;
      prevPc_q <= 32'h0000_0000;
    end else begin
      prevVld_q <= instrValid;
      prevWord_q <= instrWord;
      prevPc_q <= pcOut;
    end
  end
  wire logic rOp = prevVld_q && prevWord_q[5:0] == OpRType;
  wire logic [XopW-1:0] xop = prevWord_q[16:11];
  wire logic [DataW-1:0] nextPc = prevPc_q + InstrBytes;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_wr_nonzero; wrEn |-> wrIdx != RegZero; endproperty
  a_wr_nonzero: assert property (p_wr_nonzero) else $error("write to register zero");
  property p_brk; rOp && xop == XopBreak |-> pcOut == BreakHandlerAddr && wrEn
    && wrIdx == RegBa && wrData == nextPc; endproperty
  a_brk: assert property (p_brk) else $error("break entry wrong");
  property p_brk_st; rOp && xop == XopBreak |-> statusOut[1:0] == 2'h0
    && savedStatusOut == $past(statusOut); endproperty
  a_brk_st: assert property (p_brk_st) else $error("break status wrong");
  property p_bret; rOp && xop == XopBret |-> statusOut == $past(savedStatusOut); endproperty
  a_bret: assert property (p_bret) else $error("return status wrong");
  property p_call; prevVld_q && prevWord_q[5:0] == OpCall |-> wrIdx == RegRa
    && wrData == nextPc && pcOut == {prevPc_q[31:28], prevWord_q[31:6], 2'h0}; endproperty
  a_call: assert property (p_call) else $error("call target wrong");
  property p_callr; rOp && xop == XopCallr |-> pcOut == $past(rdDataA) && wrIdx == RegRa; endproperty
  a_callr: assert property (p_callr) else $error("register call wrong");
  property p_cmpeq; rOp && xop == XopCmpEq && prevWord_q[21:17] != RegZero |-> wrEn
    && wrData == {31'h0, $past(rdDataA) == $past(rdDataB)}; endproperty
  a_cmpeq: assert property (p_cmpeq) else $error("equal compare wrong");
  property p_cmpgeu; rOp && xop == XopCmpGeU && prevWord_q[21:17] != RegZero |-> wrEn
    && wrData == {31'h0, $past(rdDataA) >= $past(rdDataB)}; endproperty
  a_cmpgeu: assert property (p_cmpgeu) else $error("unsigned compare wrong");
  property p_unimpl; unimplPulse |-> !wrEn && pcOut == nextPc; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unknown opcode wrote");
  c_brk: cover property (rOp && xop == XopBreak);
  c_call: cover property (prevVld_q && prevWord_q[5:0] == OpCall);
  c_unimpl: cover property (unimplPulse);
endmodule
bind dcc_exec dcc_exec_chk #(.BreakHandlerAddr(BreakHandlerAddr)) chk_u (.clk(clk),
  .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord), .rdDataA(rdDataA),
  .rdDataB(rdDataB), .wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .pcOut(pcOut),
  .statusOut(statusOut), .savedStatusOut(savedStatusOut), .unimplPulse(unimplPulse));
`default_nettype wire

// ===== dv/dcc_exec_tb.sv
// self-checking bench for the debug, call and compare slice
`timescale 1ns/10ps
`default_nettype none
module dcc_exec_tb import dcc_pkg::*;;
  localparam logic [DataW-1:0] Hnd = 32'h0000_0100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instrValid = 1'b0;
  logic [DataW-1:0] instrWord = '0, rdDataA = '0, rdDataB = '0, wrData, pcOut, pc, sav;
  logic [StatusW-1:0] statusOut, savedStatusOut;
  logic [RegIdxW-1:0] wrIdx;
  logic wrEn, unimplPulse;
  int nFail = 0, testsRun = 0, cycles = 0;
  dcc_exec #(.BreakHandlerAddr(Hnd)) dut_u (.clk(clk), .rst_n(rst_n), .instrValid(instrValid),
    .instrWord(instrWord), .rdIdxA(), .rdIdxB(), .rdDataA(rdDataA), .rdDataB(rdDataB),
    .wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .pcOut(pcOut), .statusOut(statusOut),
    .savedStatusOut(savedStatusOut), .unimplPulse(unimplPulse));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      nFail++;
      tallyAndFinish();
    end
  end
  // ****
  // helpers
  // ****
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] rw(logic [4:0] a, logic [4:0] b, logic [4:0] c,
    logic [5:0] x, logic [4:0] t);
    return {a, b, c, x, t, OpRType};
  endfunction
  function automatic logic [31:0] iw(logic [4:0] b, logic [15:0] i, logic [5:0] op);
    return {5'h01, b, i, op};
  endfunction
  // one instruction, then a gap cycle; outputs sampled after the answer edge
  task automatic run(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    rdDataA <= a;
    rdDataB <= b;
    @(posedge clk);
    instrValid <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [4:0] idx, input logic [31:0] d);
    chk(32'(wrEn), 32'h1);
    chk(32'(wrIdx), 32'(idx));
    chk(wrData, d);
  endtask
  task automatic cmp(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b,
    input logic [4:0] idx, input logic r);
    run(w, a, b);
    pc = pc + InstrBytes;
    wr(idx, {31'h0, r});
    chk(pcOut, pc);
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    pc = PcRst;
    cmp(rw(5'h01, 5'h02, 5'h03, XopCmpEq, 5'h00), 5, 5, 5'h03, 1'b1);
    cmp(rw(5'h01, 5'h02, 5'h03, XopCmpEq, 5'h00), 5, 6, 5'h03, 1'b0);
    cmp(rw(5'h01, 5'h02, 5'h04, XopCmpGe, 5'h00), 32'hFFFF_FFFF, 1, 5'h04, 1'b0);
    cmp(rw(5'h01, 5'h02, 5'h04, XopCmpGe, 5'h00), 7, 7, 5'h04, 1'b1);
    cmp(rw(5'h01, 5'h02, 5'h05, XopCmpGeU, 5'h00), 32'hFFFF_FFFF, 1, 5'h05, 1'b1);
    cmp(rw(5'h01, 5'h02, 5'h05, XopCmpGeU, 5'h00), 6, 7, 5'h05, 1'b0);
    cmp(iw(5'h06, 16'hFFFF, OpCmpEqI), 32'hFFFF_FFFF, 0, 5'h06, 1'b1);
    cmp(iw(5'h06, 16'h8000, OpCmpGeI), 32'hFFFF_8000, 0, 5'h06, 1'b1);
    cmp(iw(5'h06, 16'h8000, OpCmpGeI), 32'hFFFF_7FFF, 0, 5'h06, 1'b0);
    cmp(iw(5'h07, 16'hFFFF, OpCmpGeUI), 32'h0001_0000, 0, 5'h07, 1'b1);
    cmp(iw(5'h06, 16'h0005, OpCmpGeI), 5, 0, 5'h06, 1'b1);
    cmp(iw(5'h06, 16'h0005, OpCmpGeI), 4, 0, 5'h06, 1'b0);
    run(rw(5'h02, 5'h01, 5'h03, 6'h10, 5'h00), 1, 2);
    pc = pc + InstrBytes;
    chk(32'(unimplPulse), 32'h1);
    run(rw(5'h01, 5'h02, 5'h00, XopCmpEq, 5'h00), 3, 3);
    pc = pc + InstrBytes;
    chk(32'(wrEn), 32'h0);
    run(iw(5'h02, 16'h0000, 6'h3F), 0, 0);
    pc = pc + InstrBytes;
    chk(32'(unimplPulse), 32'h1);
    chk(32'(wrEn), 32'h0);
    chk(pcOut, pc);
    $display("test compares done");
    run(rw(5'h09, 5'h00, 5'h00, XopCallr, 5'h00), 32'hA000_0010, 0);
    wr(RegRa, pc + InstrBytes);
    pc = 32'hA000_0010;
    chk(pcOut, pc);
    run({26'h123_4567, OpCall}, 0, 0);
    wr(RegRa, pc + InstrBytes);
    pc = {pc[31:28], 26'h123_4567, 2'h0};
    chk(pcOut, pc);
    $display("test calls done");
    for (int t = 0; t < 2; t++) begin
      run(rw(5'h00, 5'h00, RegBa, XopBreak, t == 0 ? 5'h00 : 5'h1F), 0, 0);
      sav = pc + InstrBytes;
      wr(RegBa, sav);
      chk(pcOut, Hnd);
      chk(statusOut, StatusRst);
      chk(savedStatusOut, StatusRst);
      run(rw(RegBa, 5'h00, 5'h00, XopBret, 5'h00), 0, 0);
      pc = sav;
      chk(pcOut, pc);
      chk(statusOut, StatusRst);
    end
    $display("test break done");
    tallyAndFinish();
  end
endmodule
`default_nettype wire
